// ==== bench/hsq_bus_model.sv ====
// far side of the two-wire port: bus master for slave tests, pull-ups, clock stretch
// assumes open-drain lines where any party's enable pulls the wire low
`timescale 1ns/1ps
module hsq_bus_model (
	input  wire logic sys_clk,
	input  wire logic clock_line_oe,
	input  wire logic data_line_oe,
	output logic      scl,
	output logic      sda
);
	localparam int HALF = 20;
	logic m_scl_low = 1'b0;
	logic m_sda_low = 1'b0;
	// ****************
	// wire resolution
	// ****************
	// pull-up: a released wire reads high, never the last driven value
	assign scl = !(clock_line_oe || m_scl_low);
	assign sda = !(data_line_oe || m_sda_low);
	task automatic gap(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : gap
	// a slave may stretch, so wait for the wire before timing the high phase
	task automatic pulse(input logic b, output logic seen);
		m_sda_low = !b;
		gap(HALF);
		m_scl_low = 1'b0;
		for (int i = 0; i < 4000 && !scl; i++)
			gap(1);
		gap(HALF);
		seen = sda;
		m_scl_low = 1'b1;
	endtask : pulse
	task automatic start();
		m_sda_low = 1'b1;
		gap(HALF);
		m_scl_low = 1'b1;
	endtask : start
	task automatic stop();
		m_sda_low = 1'b1;
		gap(HALF);
		m_scl_low = 1'b0;
		gap(HALF);
		m_sda_low = 1'b0;
		gap(HALF);
	endtask : stop
	task automatic stretch(input int n);
		m_scl_low = 1'b1;
		gap(n);
		m_scl_low = 1'b0;
	endtask : stretch
endmodule : hsq_bus_model

// ==== bench/tb_top.sv ====
// self-checking bench: slave hold and transmit against a master model, then
// master ack and stop sequences; assumes hsq_bus_model resolves both wires
`timescale 1ns/1ps
module tb_top;
	import hsq_pkg::*;
	localparam int C_REL = 6, C_IRQ = 5, C_WCL = 4, C_WR = 3, C_RD = 2, C_ACK = 1, C_STOP = 0;
	logic       sys_clk = 1'b0;
	logic       srst = 1'b1;
	logic       master_mode = 1'b0;
	logic       master_byte_done = 1'b0;
	logic       ack_value_bit = 1'b0;
	logic       address_hold_enable = 1'b0;
	logic       start_irq_enable = 1'b0;
	logic       addr_match = 1'b0;
	logic       clock_line_out, data_line_out;
	logic [7:0] baud_reload = 8'h03;
	logic [7:0] buf_wdata = 8'h00;
	hsq_ctl_t   ctl = '0;
	hsq_stat_t  stat;
	logic [7:0] serial_buffer;
	logic       clock_line_oe, data_line_oe, scl, sda, master_idle, seen;
	int         n_mismatch = 0, checked = 0, cyc = 0;

	hsq_port #(.BRG_W(8)) dut_u (.sys_clk(sys_clk), .srst(srst), .clock_line_in(scl),
		.clock_line_out(clock_line_out), .clock_line_oe(clock_line_oe), .data_line_in(sda),
		.data_line_out(data_line_out), .data_line_oe(data_line_oe),
		.address_hold_enable(address_hold_enable), .start_irq_enable(start_irq_enable),
		.addr_match(addr_match), .ack_value_bit(ack_value_bit),
		.master_mode(master_mode), .master_byte_done(master_byte_done),
		.baud_reload(baud_reload), .ctl(ctl), .buf_wdata(buf_wdata),
		.serial_buffer(serial_buffer), .stat(stat), .master_idle(master_idle));
	hsq_bus_model bm_u (.sys_clk(sys_clk), .clock_line_oe(clock_line_oe),
		.data_line_oe(data_line_oe), .scl(scl), .sda(sda));

	always #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			wrap_up();
		end
	end
	// ****************
	// helpers
	// ****************
	task automatic wrap_up();
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic pulse_ctl(input int k, input logic [7:0] v);
		ctl = hsq_ctl_t'(7'h01 << k);
		buf_wdata = v;
		@(negedge sys_clk);
		ctl = '0;
	endtask : pulse_ctl
	function automatic logic sel(input int k);
		case (k)
			0: sel = clock_line_oe;
			1: sel = data_line_oe;
			2: sel = !stat.stop_detected;
			3: sel = stat.stop_sequence_start;
			default: sel = stat.ack_sequence_start;
		endcase
	endfunction : sel
	// bounded so a stuck sequence ends in a mismatch, not a hang
	task automatic hold_cnt(input int k, output int n);
		n = 0;
		while (sel(k) === 1'b1 && n < 3000) begin
			@(negedge sys_clk);
			n++;
		end
	endtask : hold_cnt
	// ****************
	// main sequence
	// ****************
	initial begin
		int n, t, p;
		logic [7:0] a, d, got, be;
		void'($urandom(32'h6276));
		repeat (16) @(negedge sys_clk);
		srst = 1'b0;
		chk(stat, 12'h004);
		chk({clock_line_out, data_line_out}, 2'b00);
		// no match and no start irq: nothing may hold the clock or raise irq
		address_hold_enable = 1'($urandom);
		a = 8'($urandom);
		bm_u.start();
		bm_u.gap(8);
		chk({stat.start_detected, stat.serial_port_irq_flag}, 2'b10);
		for (int i = 7; i >= 0; i--)
			bm_u.pulse(a[i], seen);
		bm_u.gap(8);
		chk({stat.clock_release_bit, clock_line_oe, stat.serial_port_irq_flag}, 3'b100);
		chk({stat.ack_phase_flag, stat.read_not_write, serial_buffer}, {1'b0, a[0], a});
		bm_u.pulse(1'b1, seen);
		chk(seen, 1'b1);
		bm_u.stop();
		chk(stat.stop_detected, 1'b1);
		address_hold_enable = 1'b1;
		start_irq_enable = 1'b1;
		addr_match = 1'b1;
		a = {7'($urandom), 1'b1};
		bm_u.start();
		bm_u.gap(8);
		chk({stat.start_detected, stat.serial_port_irq_flag}, 2'b11);
		pulse_ctl(C_IRQ, 8'h00);
		chk(stat.serial_port_irq_flag, 1'b0);
		for (int i = 7; i >= 0; i--)
			bm_u.pulse(a[i], seen);
		bm_u.gap(8);
		chk({stat.clock_release_bit, clock_line_oe, stat.serial_port_irq_flag}, 3'b011);
		chk({stat.ack_phase_flag, stat.read_not_write, stat.data_not_address}, 3'b110);
		chk(serial_buffer, a);
		pulse_ctl(C_RD, 8'h00);
		chk(stat.buffer_full_flag, 1'b0);
		pulse_ctl(C_IRQ, 8'h00);
		pulse_ctl(C_REL, 8'h00);
		chk({stat.clock_release_bit, clock_line_oe}, 2'b10);
		bm_u.pulse(1'b1, seen);
		chk(seen, 1'b0);
		bm_u.gap(8);
		chk({stat.clock_release_bit, stat.serial_port_irq_flag}, 2'b01);
		// first byte acked (hold again), second not-acked (bus released)
		for (int j = 0; j < 2; j++) begin
			d = 8'($urandom);
			pulse_ctl(C_IRQ, 8'h00);
			pulse_ctl(C_WR, d);
			chk(stat.buffer_full_flag, 1'b1);
			pulse_ctl(C_REL, 8'h00);
			chk({stat.clock_release_bit, clock_line_oe}, 2'b10);
			for (int i = 7; i >= 0; i--) begin
				bm_u.pulse(1'b1, seen);
				got[i] = seen;
			end
			chk(got, d);
			bm_u.pulse(j == 1, seen);
			bm_u.gap(8);
			chk(stat.received_ack_bit, j == 1);
			chk({clock_line_oe, stat.serial_port_irq_flag}, {2{j == 0}});
			chk(stat.clock_release_bit, j == 1);
		end
		bm_u.stop();
		// second reset clears the stop flag left by the slave pass
		srst = 1'b1;
		repeat (2) @(negedge sys_clk);
		srst = 1'b0;
		master_mode = 1'b1;
		master_byte_done = 1'b1;
		@(negedge sys_clk);
		master_byte_done = 1'b0;
		chk(clock_line_oe, 1'b1);
		be = serial_buffer;
		for (int i = 0; i < 4; i++) begin
			p = $urandom_range(9, 2) + 1;
			baud_reload = 8'(p - 1);
			ack_value_bit = 1'($urandom);
			if (i == 3) begin
				fork
					bm_u.stretch(40);
				join_none
			end
			pulse_ctl(C_ACK, 8'h00);
			chk({clock_line_oe, data_line_oe}, {1'b1, !ack_value_bit});
			pulse_ctl(C_WR, 8'h3c);
			chk({stat.write_collision_flag, serial_buffer}, {1'b1, be});
			hold_cnt(4, n);
			n = n + 1;
			t = p + (i == 3 ? 40 : p);
			chk(n >= t && n <= t + 8, 1'b1);
			chk({stat.ack_sequence_start, master_idle, clock_line_oe}, 3'b011);
		end
		pulse_ctl(C_WCL, 8'h00);
		chk(stat.write_collision_flag, 1'b0);
		pulse_ctl(C_IRQ, 8'h00);
		pulse_ctl(C_STOP, 8'h00);
		chk(data_line_oe, 1'b1);
		pulse_ctl(C_WR, 8'h5a);
		chk({stat.write_collision_flag, serial_buffer}, {1'b1, be});
		hold_cnt(0, n);
		chk(n >= p && n <= p + 8, 1'b1);
		hold_cnt(1, n);
		chk(n >= p - 1 && n <= p + 1, 1'b1);
		hold_cnt(2, n);
		chk(stat.stop_detected, 1'b1);
		hold_cnt(3, n);
		chk(n >= p - 1 && n <= p + 1, 1'b1);
		chk({stat.serial_port_irq_flag, stat.write_collision_flag}, 2'b11);
		pulse_ctl(C_IRQ, 8'h00);
		chk(stat.serial_port_irq_flag, 1'b0);
		wrap_up();
	end
endmodule : tb_top

// ==== logic/hsq_pkg.sv ====
// constants and carriers for the two-wire hold/ack/stop block
// assumes one system clock; pins are open-drain and resolved outside
package hsq_pkg;
	localparam int          HSQ_BITS_PER_BYTE = 8;
	localparam logic [3:0]  HSQ_ACK_EDGE      = 4'h9;
	localparam logic [3:0]  HSQ_DATA_EDGE     = 4'h8;
	localparam logic        HSQ_CKP_RST       = 1'h1;
	localparam logic [7:0]  HSQ_BUF_RST       = 8'h00;
	localparam logic        HSQ_FLAG_RST      = 1'h0;
	localparam logic        HSQ_LINE_RST      = 1'h1;

	// one-cycle software pulses
	typedef struct packed {
		logic clock_release_set;
		logic irq_clear;
		logic write_collision_flag_clear;
		logic buf_write;
		logic buf_read;
		logic ack_seq_set;
		logic stop_seq_set;
	} hsq_ctl_t;

	typedef struct packed {
		logic serial_port_irq_flag;
		logic write_collision_flag;
		logic buffer_full_flag;
		logic ack_phase_flag;
		logic read_not_write;
		logic data_not_address;
		logic start_detected;
		logic stop_detected;
		logic received_ack_bit;
		logic clock_release_bit;
		logic ack_sequence_start;
		logic stop_sequence_start;
	} hsq_stat_t;
endpackage : hsq_pkg

// ==== logic/hsq_port.sv ====
// slave hold/transmit path and master ack/stop sequencer of a two-wire port
// assumes address matching, start generation and the byte shifter of
// master mode live elsewhere; lines are open-drain, enable high pulls low
//
// Function
// - address hold on: after 8th fall of matching address, hold clock, raise irq.
// - start seen sets start flag; irq too when start interrupt enabled.
// - ack phase, read/write and data/address indicators visible to software.
// - reading the buffer that holds the address clears buffer-full.
// - setting clock release stops holding the clock low.
// - in reads, after each ack hardware clears clock release and raises irq.
// - writing transmit byte sets buffer-full; load only after the ack.
// - master's ack on ninth pulse of each sent byte stored as received ack.
// - not-ack from master makes slave release the bus.
// - ack sequence start pulls clock low, puts ack value on data.
// - ack value zero gives ack, one gives not-ack.
// - wait one baud period, release clock, once high wait one more, pull low.
// - ack sequence end clears its start bit, stops baud counter, goes idle.
// - buffer write during ack sequence sets collision, buffer unchanged.
// - master holds clock low after ninth falling edge.
// - stop start pulls data low; once low, baud counter reloads and counts down to zero.
// - baud timeout releases clock, one period later releases data.
// - data seen high while clock high sets stop flag.
// - one period after stop, clear stop start bit and raise irq.
// - buffer write during stop sequence sets collision, write dropped.
`timescale 1ns/1ps
module hsq_port #(
	parameter int BRG_W = 8
) (
	input  wire logic                sys_clk,
	input  wire logic                srst,
	input  wire logic                clock_line_in,
	output logic                     clock_line_out,
	output logic                     clock_line_oe,
	input  wire logic                data_line_in,
	output logic                     data_line_out,
	output logic                     data_line_oe,
	input  wire logic                address_hold_enable,
	input  wire logic                start_irq_enable,
	input  wire logic                addr_match,
	input  wire logic                ack_value_bit,
	input  wire logic                master_mode,
	input  wire logic                master_byte_done,
	input  wire logic [BRG_W-1:0]    baud_reload,
	input  wire hsq_pkg::hsq_ctl_t   ctl,
	input  wire logic [7:0]          buf_wdata,
	output logic [7:0]               serial_buffer,
	output hsq_pkg::hsq_stat_t       stat,
	output logic                     master_idle
);
	import hsq_pkg::*;

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [2:0] scl_s_r;
	logic [2:0] sda_s_r;
	logic       scl_f_r;
	logic       sda_f_r;
	logic       scl_d_r;
	logic       sda_d_r;

	// change counts once the second and third stages agree
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			scl_s_r <= {3{HSQ_LINE_RST}};
			sda_s_r <= {3{HSQ_LINE_RST}};
			scl_f_r <= HSQ_LINE_RST;
			sda_f_r <= HSQ_LINE_RST;
			scl_d_r <= HSQ_LINE_RST;
			sda_d_r <= HSQ_LINE_RST;
		end else begin
			scl_s_r <= {scl_s_r[1:0], clock_line_in};
			sda_s_r <= {sda_s_r[1:0], data_line_in};
			if (scl_s_r[1] == scl_s_r[2]) scl_f_r <= scl_s_r[2];
			if (sda_s_r[1] == sda_s_r[2]) sda_f_r <= sda_s_r[2];
			scl_d_r <= scl_f_r;
			sda_d_r <= sda_f_r;
		end
	end

	wire scl_rise  = scl_f_r & ~scl_d_r;
	wire scl_fall  = ~scl_f_r & scl_d_r;
	wire start_ev  = scl_f_r & scl_d_r & ~sda_f_r & sda_d_r;
	wire stop_ev   = scl_f_r & scl_d_r & sda_f_r & ~sda_d_r;

	// ****************************************
	// master sequencer
	// ****************************************
	typedef enum logic [3:0] {
		M_IDLE, A_LOW, A_REL, A_HIGH, P_WAIT, P_LOW, P_SCL, P_REL, P_END
	} hsq_mst_t;

	hsq_mst_t         mst_r, mst_nxt;
	logic [BRG_W-1:0] brg_r, brg_nxt;
	logic             hold_r, hold_nxt;
	logic             stop_done;

	wire brg_zero  = (brg_r == '0);
	wire ack_busy  = (mst_r inside {A_LOW, A_REL, A_HIGH});
	wire stop_busy = (mst_r inside {P_WAIT, P_LOW, P_SCL, P_REL, P_END});
	wire collide   = ctl.buf_write & (ack_busy | stop_busy);

	always_comb begin
		mst_nxt   = mst_r;
		brg_nxt   = brg_zero ? '0 : brg_r - 1'b1;
		hold_nxt  = hold_r | master_byte_done;
		stop_done = 1'b0;
		case (mst_r)
			M_IDLE: begin
				brg_nxt = '0;
				if (master_mode & ctl.ack_seq_set) begin
					mst_nxt = A_LOW;
					brg_nxt = baud_reload;
				end else if (master_mode & ctl.stop_seq_set) begin
					mst_nxt = P_WAIT;
				end
			end
			A_LOW: if (brg_zero) mst_nxt = A_REL;
			A_REL: if (scl_f_r) begin
				mst_nxt = A_HIGH;
				brg_nxt = baud_reload;
			end
			A_HIGH: if (brg_zero) begin
				mst_nxt  = M_IDLE;
				hold_nxt = 1'b1;
			end
			P_WAIT: if (~sda_f_r) begin
				mst_nxt = P_LOW;
				brg_nxt = baud_reload;
			end
			P_LOW: if (brg_zero) begin
				mst_nxt  = P_SCL;
				hold_nxt = 1'b0;
				brg_nxt  = baud_reload;
			end
			P_SCL: if (brg_zero) mst_nxt = P_REL;
			P_REL: if (sda_f_r & scl_f_r) begin
				mst_nxt = P_END;
				brg_nxt = baud_reload;
			end
			P_END: if (brg_zero) begin
				mst_nxt   = M_IDLE;
				stop_done = 1'b1;
			end
			default: mst_nxt = M_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			mst_r  <= M_IDLE;
			brg_r  <= '0;
			hold_r <= 1'b0;
		end else begin
			mst_r  <= mst_nxt;
			brg_r  <= brg_nxt;
			hold_r <= hold_nxt;
		end
	end

	// ****************************************
	// slave hold and transmit
	// ****************************************
	typedef enum logic [1:0] {S_IDLE, S_ADDR, S_TX} hsq_slv_t;

	hsq_slv_t   slv_r;
	logic [3:0] cnt_r;
	logic [7:0] rx_r;
	logic [7:0] tx_r;
	logic       match_r;

	wire fall_n      = scl_fall & (slv_r != S_IDLE);
	wire addr_done   = fall_n & (slv_r == S_ADDR) & (cnt_r == HSQ_DATA_EDGE - 4'h1);
	wire addr_ack    = fall_n & (slv_r == S_ADDR) & (cnt_r == HSQ_DATA_EDGE);
	wire tx_ack_rise = scl_rise & (slv_r == S_TX) & (cnt_r == HSQ_DATA_EDGE);
	wire tx_ack_fall = fall_n & (slv_r == S_TX) & (cnt_r == HSQ_DATA_EDGE);
	wire hold_now    = address_hold_enable & addr_match;
	wire rd_go       = addr_ack & match_r & stat.read_not_write;
	wire tx_go       = tx_ack_fall & ~stat.received_ack_bit;
	wire irq_set     = (addr_done & hold_now) | rd_go | tx_go
	                 | (start_ev & start_irq_enable) | stop_done;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			slv_r   <= S_IDLE;
			cnt_r   <= 4'h0;
			rx_r    <= HSQ_BUF_RST;
			tx_r    <= HSQ_BUF_RST;
			match_r <= HSQ_FLAG_RST;
		end else if (start_ev) begin
			slv_r <= S_ADDR;
			cnt_r <= 4'hf;  // the start's own clock fall wraps this to zero
		end else begin
			if (scl_rise) rx_r <= {rx_r[6:0], sda_f_r};
			if (fall_n) cnt_r <= cnt_r + 4'h1;
			if (addr_done) match_r <= addr_match;
			if (slv_r == S_TX && fall_n) tx_r <= {tx_r[6:0], 1'b1};
			if (stat.clock_release_bit == 1'b0 && ctl.clock_release_set && slv_r == S_TX)
				tx_r <= serial_buffer;
			if (addr_ack) begin
				slv_r <= rd_go ? S_TX : S_IDLE;
				cnt_r <= 4'h0;
			end
			if (tx_ack_fall) begin
				slv_r <= tx_go ? S_TX : S_IDLE;
				cnt_r <= 4'h0;
			end
			if (stop_ev) slv_r <= S_IDLE;
		end
	end

	// ****************************************
	// status flags and buffer
	// ****************************************
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			stat          <= '0;
			stat.clock_release_bit <= HSQ_CKP_RST;
			serial_buffer <= HSQ_BUF_RST;
		end else begin
			// for irq, collision and buffer-full the set is listed last and wins a same-cycle clear; for clock_release_bit the hold clear is listed last and wins
			if (ctl.irq_clear) stat.serial_port_irq_flag <= 1'b0;
			if (irq_set) stat.serial_port_irq_flag <= 1'b1;
			if (ctl.write_collision_flag_clear) stat.write_collision_flag <= 1'b0;
			if (collide) stat.write_collision_flag <= 1'b1;
			if (ctl.buf_read) stat.buffer_full_flag <= 1'b0;
			if (ctl.buf_write & ~collide) begin
				serial_buffer <= buf_wdata;
				stat.buffer_full_flag <= 1'b1;
			end
			if (addr_done) begin
				serial_buffer          <= rx_r;
				stat.buffer_full_flag  <= 1'b1;
				stat.read_not_write    <= rx_r[0];
				stat.data_not_address  <= 1'b0;
				stat.ack_phase_flag    <= hold_now;
			end
			if (tx_ack_rise) begin
				stat.received_ack_bit <= sda_f_r;
				stat.ack_phase_flag   <= 1'b1;
			end
			if (addr_ack | tx_ack_fall) stat.ack_phase_flag <= 1'b0;
			if (rd_go) stat.data_not_address <= 1'b1;
			if (ctl.clock_release_set) stat.clock_release_bit <= 1'b1;
			if ((addr_done & hold_now) | rd_go | tx_go)
				stat.clock_release_bit <= 1'b0;
			if (start_ev) stat.start_detected <= 1'b1;
			if (stop_ev) stat.stop_detected <= 1'b1;
			if (start_ev) stat.stop_detected <= 1'b0;
			if (stop_ev) stat.start_detected <= 1'b0;
			if (master_mode & ctl.ack_seq_set & mst_r == M_IDLE)
				stat.ack_sequence_start <= 1'b1;
			if (mst_r == A_HIGH && brg_zero) stat.ack_sequence_start <= 1'b0;
			if (master_mode & ctl.stop_seq_set & mst_r == M_IDLE & ~ctl.ack_seq_set)
				stat.stop_sequence_start <= 1'b1;
			if (stop_done) stat.stop_sequence_start <= 1'b0;
		end
	end

	// ****************************************
	// line drivers
	// ****************************************
	wire slv_scl = (slv_r != S_IDLE) & ~stat.clock_release_bit;
	wire slv_sda = ((slv_r == S_ADDR) & (cnt_r == HSQ_DATA_EDGE) & match_r & ~ack_value_bit)
	             | ((slv_r == S_TX) & (cnt_r < HSQ_DATA_EDGE) & ~tx_r[7]);
	wire mst_scl = (mst_r == A_LOW) | (mst_r == P_WAIT) | (mst_r == P_LOW)
	             | ((mst_r == M_IDLE) & master_mode & hold_r);
	wire mst_sda = (ack_busy & ~ack_value_bit)
	             | (mst_r inside {P_WAIT, P_LOW, P_SCL});

	assign clock_line_out = 1'b0;
	assign data_line_out  = 1'b0;
	assign clock_line_oe  = slv_scl | mst_scl;
	assign data_line_oe   = slv_sda | mst_sda;
	assign master_idle    = (mst_r == M_IDLE);

	// ****************************************
	// checks
	// ****************************************
	sequence s_ack_rel;
		(mst_r == A_REL) ##1 scl_f_r;
	endsequence

	property p_ack_sda;
		@(posedge sys_clk) disable iff (srst)
		(mst_r == A_LOW) |-> (data_line_oe == ~ack_value_bit);
	endproperty
	a_ack_sda: assert property (p_ack_sda) else $error("ack data wrong");
	property p_ack_seq;
		@(posedge sys_clk) disable iff (srst)
		(mst_r == M_IDLE && master_mode && ctl.ack_seq_set) |=> clock_line_oe;
	endproperty
	a_ack_seq: assert property (p_ack_seq) else $error("ack clock not low");
	property p_ack_high;
		@(posedge sys_clk) disable iff (srst)
		s_ack_rel |-> ##1 (mst_r == A_HIGH) && !clock_line_oe;
	endproperty
	a_ack_high: assert property (p_ack_high) else $error("ack high phase");
	property p_ack_end;
		@(posedge sys_clk) disable iff (srst)
		(mst_r == A_HIGH && brg_zero) |=> !stat.ack_sequence_start && master_idle;
	endproperty
	a_ack_end: assert property (p_ack_end) else $error("ack not ended");
	property p_write_collision_flag;
		@(posedge sys_clk) disable iff (srst)
		(ctl.buf_write && !master_idle) |=>
			stat.write_collision_flag && serial_buffer == $past(serial_buffer);
	endproperty
	a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision missed");
	property p_stop_sda;
		@(posedge sys_clk) disable iff (srst)
		(master_idle && master_mode && ctl.stop_seq_set && !ctl.ack_seq_set) |=>
			data_line_oe && stat.stop_sequence_start;
	endproperty
	a_stop_sda: assert property (p_stop_sda) else $error("stop data not low");
	property p_stop_end;
		@(posedge sys_clk) disable iff (srst)
		stop_done |=> stat.serial_port_irq_flag && !stat.stop_sequence_start;
	endproperty
	a_stop_end: assert property (p_stop_end) else $error("stop not ended");
	property p_irq_hold;
		@(posedge sys_clk) disable iff (srst)
		(stat.serial_port_irq_flag && !ctl.irq_clear) |=> stat.serial_port_irq_flag;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
	property p_addr_hold;
		@(posedge sys_clk) disable iff (srst)
		(addr_done && hold_now) |=> !stat.clock_release_bit && stat.serial_port_irq_flag;
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("no address hold");
	property p_stop_det;
		@(posedge sys_clk) disable iff (srst)
		stop_ev |=> stat.stop_detected;
	endproperty
	a_stop_det: assert property (p_stop_det) else $error("stop not flagged");
endmodule : hsq_port
